// ### hw/oscctl_startup_counter.sv
// Counter of raw resonator clock edges that flags the end of startup.
`timescale 1ns/1ps
module oscctl_startup_counter (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic clkEn,
   input  wire logic clear,
   input  wire logic tick,
   output logic      startupCountDone
);

   logic [oscctl_pkg::CNT_W-1:0] count_reg;
   logic                         done_reg;

   // ****************************************************************
   // Edge counter
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= oscctl_pkg::CNT_RESET;
      end else if (clkEn) begin
         if (clear) begin
            count_reg <= oscctl_pkg::CNT_RESET;
         end else if (tick && (count_reg != oscctl_pkg::STARTUP_COUNT)) begin
            count_reg <= count_reg + 13'h0001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         done_reg <= 1'b0;
      end else if (clkEn) begin
         done_reg <= !clear && (count_reg == oscctl_pkg::STARTUP_COUNT);
      end
   end

   assign startupCountDone = done_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_done_after_full_count;
      @(posedge core_clk) disable iff (!nrst)
      $rose(done_reg) |-> count_reg == oscctl_pkg::STARTUP_COUNT;
   endproperty
   a_done_after_full_count: assert property (p_done_after_full_count)
      else $error("Startup done raised before the full edge count.");

   property p_clear_restarts;
      @(posedge core_clk) disable iff (!nrst)
      (clear && clkEn) |=> (!done_reg && count_reg == oscctl_pkg::CNT_RESET);
   endproperty
   a_clear_restarts: assert property (p_clear_restarts)
      else $error("Counter or done flag survived a clear.");

endmodule

// ### hw/oscctl_top.sv
// Oscillator enable, startup sequencing and mode control with its register slave.
//
// Functional notes
// - The enable is on when the clock generator asks, or when software enables and the MCU is not in stop or stop keep-alive is set.
// - Whenever the enable is low the block goes to the off state.
// - In the off state the raw clock and the output clock are held static.
// - In the off state the pins are decoupled and the analog core draws minimum current.
// - A rising enable with the oscillator selected enters startup, amplifier on, output withheld.
// - Raw clock edges are counted and the output stays gated until 4096 have been seen.
// - Enable high, oscillator selected and count done means the stable state with the raw clock passed out.
// - Enable high with the external source selected buffers the crystal input pin to the output, skipping the count.
// - Range bit picks low or high frequency, gain bit picks high-gain inverter or low-power gain loop.
// - The differential input buffer is used only in high-frequency low-power mode.
// - Oscillator mode uses both crystal pins, external clock mode only the input pin.
// - A read-only init-done bit shows completion of the startup count and reads 0 before that.
// - Output select 0 picks the external clock on the input pin, 1 the internal oscillator.
`timescale 1ns/1ps
module oscctl_top (
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic                  clkEn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic                  clockGenRequest,
   input  wire logic                  mcuStop,
   input  wire logic                  rawResonatorClock,
   input  wire logic                  crystalInputPin,
   output logic                       moduleOutputClock,
   output logic                       rawClockGated,
   output logic                       initDoneFlag,
   output logic                       oscEnable,
   output oscctl_pkg::oscctl_analog_t analogCtrl
);

   logic [7:0]                  ctrl_reg;
   logic [7:0]                  ctrl_next;
   oscctl_pkg::oscctl_state_t   state_reg;
   oscctl_pkg::oscctl_state_t   state_next;
   logic                        dphWrite_reg;
   logic [oscctl_pkg::ADDR_W-1:0] dphAddr_reg;
   logic [31:0]                 hrdata_reg;
   logic                        rawS1_reg;
   logic                        rawS2_reg;
   logic                        rawS3_reg;
   logic                        extS1_reg;
   logic                        extS2_reg;
   logic                        outClk_reg;
   logic                        rawGated_reg;
   oscctl_pkg::oscctl_analog_t  analog_reg;
   oscctl_pkg::oscctl_analog_t  analog_next;
   logic                        enable;
   logic                        takeAddr;
   logic                        countDone;
   logic                        countClear;
   logic                        oscPathNext;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic oscOn(input oscctl_pkg::oscctl_state_t s);
      oscOn = (s == oscctl_pkg::OSC_STARTUP) || (s == oscctl_pkg::OSC_STABLE);
   endfunction

   function automatic logic [31:0] regRead(input logic [oscctl_pkg::ADDR_W-1:0] a,
                                           input logic [7:0] c,
                                           input logic d,
                                           input oscctl_pkg::oscctl_state_t s,
                                           input logic e);
      regRead = 32'h00000000;
      if (a == oscctl_pkg::CTRL_OFFSET) begin
         regRead[7:0] = c & oscctl_pkg::CTRL_WMASK;
         regRead[oscctl_pkg::INIT_BIT] = d;
      end else if (a == oscctl_pkg::STATUS_OFFSET) begin
         regRead[1:0] = s;
         regRead[2] = e;
         regRead[3] = d;
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rawS1_reg <= 1'b0;
         rawS2_reg <= 1'b0;
         rawS3_reg <= 1'b0;
      end else if (clkEn) begin
         rawS1_reg <= rawResonatorClock;
         rawS2_reg <= rawS1_reg;
         rawS3_reg <= rawS2_reg;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         extS1_reg <= 1'b0;
         extS2_reg <= 1'b0;
      end else if (clkEn) begin
         extS1_reg <= crystalInputPin;
         extS2_reg <= extS1_reg;
      end
   end

   // ****************************************************************
   // Register slave
   // ****************************************************************
   assign takeAddr = hsel && hready && clkEn && (htrans == oscctl_pkg::HTRANS_NONSEQ)
                     && (hsize == oscctl_pkg::HSIZE_WORD);

   always_comb begin
      ctrl_next = ctrl_reg;
      if (dphWrite_reg && (dphAddr_reg == oscctl_pkg::CTRL_OFFSET)) begin
         ctrl_next = (ctrl_reg & ~oscctl_pkg::CTRL_WMASK)
                     | (hwdata[7:0] & oscctl_pkg::CTRL_WMASK);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= oscctl_pkg::CTRL_RESET;
      end else if (clkEn) begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dphWrite_reg <= 1'b0;
         dphAddr_reg  <= 8'h00;
      end else if (clkEn) begin
         dphWrite_reg <= takeAddr && hwrite;
         dphAddr_reg  <= haddr[oscctl_pkg::ADDR_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hrdata_reg <= 32'h00000000;
      end else if (takeAddr && !hwrite) begin
         hrdata_reg <= regRead(haddr[oscctl_pkg::ADDR_W-1:0], ctrl_next, countDone,
                               state_next, enable);
      end
   end

   assign hreadyout = clkEn;
   assign hresp     = oscctl_pkg::HRESP_OKAY;
   assign hrdata    = hrdata_reg;

   // ****************************************************************
   // Enable decode and state machine
   // ****************************************************************
   assign enable = clockGenRequest || (ctrl_reg[oscctl_pkg::EN_BIT]
                   && (!mcuStop || ctrl_reg[oscctl_pkg::KEEP_BIT]));

   always_comb begin
      case (enable)
         1'b0: state_next = oscctl_pkg::OSC_OFF;
         default: begin
            if (!ctrl_reg[oscctl_pkg::SEL_BIT]) begin
               state_next = oscctl_pkg::OSC_EXTCLK;
            end else if (countDone) begin
               state_next = oscctl_pkg::OSC_STABLE;
            end else begin
               state_next = oscctl_pkg::OSC_STARTUP;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= oscctl_pkg::OSC_OFF;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Startup counter
   // ****************************************************************
   assign oscPathNext = oscOn(state_next);
   assign countClear  = !oscPathNext;

   oscctl_startup_counter u_counter (
      .core_clk         (core_clk),
      .nrst             (nrst),
      .clkEn            (clkEn),
      .clear            (countClear),
      .tick             (rawS2_reg && !rawS3_reg && oscOn(state_reg)),
      .startupCountDone (countDone)
   );

   // ****************************************************************
   // Clock outputs
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         outClk_reg   <= 1'b0;
         rawGated_reg <= 1'b0;
      end else if (clkEn) begin
         case (state_next)
            oscctl_pkg::OSC_STABLE: outClk_reg <= rawS2_reg;
            oscctl_pkg::OSC_EXTCLK: outClk_reg <= extS2_reg;
            default:                outClk_reg <= 1'b0;
         endcase
         rawGated_reg <= oscPathNext && rawS2_reg;
      end
   end

   // ****************************************************************
   // Analog mode controls
   // ****************************************************************
   always_comb begin
      analog_next              = oscctl_pkg::ANALOG_RESET;
      analog_next.ampEnable    = oscPathNext;
      analog_next.pinsCoupled  = (state_next != oscctl_pkg::OSC_OFF);
      analog_next.drivePinUsed = oscPathNext;
      analog_next.highFreq     = ctrl_reg[oscctl_pkg::RANGE_BIT];
      analog_next.highGain     = ctrl_reg[oscctl_pkg::GAIN_BIT];
      analog_next.gainLoop     = oscPathNext && !ctrl_reg[oscctl_pkg::GAIN_BIT];
      analog_next.diffBuffer   = oscPathNext && ctrl_reg[oscctl_pkg::RANGE_BIT]
                                 && !ctrl_reg[oscctl_pkg::GAIN_BIT];
      analog_next.minCurrent   = (state_next == oscctl_pkg::OSC_OFF);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         analog_reg <= oscctl_pkg::ANALOG_RESET;
      end else if (clkEn) begin
         analog_reg <= analog_next;
      end
   end

   assign moduleOutputClock = outClk_reg;
   assign rawClockGated     = rawGated_reg;
   assign initDoneFlag      = countDone;
   assign oscEnable         = enable;
   assign analogCtrl        = analog_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_request_enables;
      (clockGenRequest && clkEn) |=> (state_reg != oscctl_pkg::OSC_OFF);
   endproperty
   a_request_enables: assert property (p_request_enables)
      else $error("Clock generator request did not keep the oscillator on.");

   property p_off_on_disable;
      (!enable && clkEn) |=> (state_reg == oscctl_pkg::OSC_OFF);
   endproperty
   a_off_on_disable: assert property (p_off_on_disable)
      else $error("Disabled oscillator left the off state.");

   property p_off_static;
      (state_reg == oscctl_pkg::OSC_OFF) |-> (!outClk_reg && !rawGated_reg);
   endproperty
   a_off_static: assert property (p_off_static)
      else $error("Clock edge seen in the off state.");

   property p_off_decoupled;
      (state_reg == oscctl_pkg::OSC_OFF)
         |-> (!analog_reg.pinsCoupled && analog_reg.minCurrent && !analog_reg.ampEnable);
   endproperty
   a_off_decoupled: assert property (p_off_decoupled)
      else $error("Analog core not idle in the off state.");

   property p_rise_to_startup;
      (clkEn && $past(clkEn) && $rose(enable) && ctrl_reg[oscctl_pkg::SEL_BIT])
         |=> (state_reg == oscctl_pkg::OSC_STARTUP) && analog_reg.ampEnable;
   endproperty
   a_rise_to_startup: assert property (p_rise_to_startup)
      else $error("Enable rise did not start the oscillator.");

   property p_startup_gated;
      (state_reg == oscctl_pkg::OSC_STARTUP)
         |-> !outClk_reg && (!initDoneFlag || $rose(initDoneFlag) || !$past(clkEn));
   endproperty
   a_startup_gated: assert property (p_startup_gated)
      else $error("Output clock passed during startup.");

   property p_stable_when_done;
      (enable && ctrl_reg[oscctl_pkg::SEL_BIT] && countDone && clkEn)
         |=> (state_reg == oscctl_pkg::OSC_STABLE);
   endproperty
   a_stable_when_done: assert property (p_stable_when_done)
      else $error("Counted oscillator not in the stable state.");

   property p_ext_follows_pin;
      (clkEn && enable && !ctrl_reg[oscctl_pkg::SEL_BIT])
         |=> (state_reg == oscctl_pkg::OSC_EXTCLK) && (outClk_reg == $past(extS2_reg));
   endproperty
   a_ext_follows_pin: assert property (p_ext_follows_pin)
      else $error("External clock not buffered to the output.");

   property p_diff_buffer_mode;
      analog_reg.diffBuffer |-> (analog_reg.highFreq && !analog_reg.highGain
                                 && oscOn(state_reg));
   endproperty
   a_diff_buffer_mode: assert property (p_diff_buffer_mode)
      else $error("Differential buffer used outside high-frequency low-power mode.");

   property p_ext_frees_drive;
      (state_reg == oscctl_pkg::OSC_EXTCLK) |-> !analog_reg.drivePinUsed;
   endproperty
   a_ext_frees_drive: assert property (p_ext_frees_drive)
      else $error("Drive pin claimed in external clock mode.");

   c_enter_startup: cover property ($rose(state_reg == oscctl_pkg::OSC_STARTUP));
   c_enter_stable: cover property ($rose(state_reg == oscctl_pkg::OSC_STABLE));
   c_enter_extclk: cover property ($rose(state_reg == oscctl_pkg::OSC_EXTCLK));
   c_stable_to_off: cover property ((state_reg == oscctl_pkg::OSC_STABLE)
                                    ##1 (state_reg == oscctl_pkg::OSC_OFF));

endmodule

// ### pkg/oscctl_pkg.sv
// Shared constants, types and register layout of the oscillator control block.
package oscctl_pkg;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] CTRL_WMASK    = 8'hb6;
   localparam int         EN_BIT        = 7;
   localparam int         KEEP_BIT      = 5;
   localparam int         SEL_BIT       = 4;
   localparam int         RANGE_BIT     = 2;
   localparam int         GAIN_BIT      = 1;
   localparam int         INIT_BIT      = 0;

   // ****************************************************************
   // Bus encodings
   // ****************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // ****************************************************************
   // Startup counter
   // ****************************************************************
   localparam int          CNT_W         = 13;
   localparam logic [12:0] STARTUP_COUNT = 13'h1000;
   localparam logic [12:0] CNT_RESET     = 13'h0000;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      OSC_OFF     = 2'b00,
      OSC_STARTUP = 2'b01,
      OSC_STABLE  = 2'b10,
      OSC_EXTCLK  = 2'b11
   } oscctl_state_t;

   typedef struct packed {
      logic ampEnable;
      logic pinsCoupled;
      logic drivePinUsed;
      logic highFreq;
      logic highGain;
      logic gainLoop;
      logic diffBuffer;
      logic minCurrent;
   } oscctl_analog_t;

   localparam oscctl_analog_t ANALOG_RESET = 8'h01;

endpackage

// ### testbench/oscctl_resonator_model.sv
// Behavioural model of the crystal, resonator or external clock source on the pins.
`timescale 1ns/1ps
module oscctl_resonator_model (
   input  wire logic ampOn,
   input  wire logic extOn,
   input  wire logic slow,
   output logic      rawClk,
   output logic      pinClk
);
   // ****************************************************************
   // Resonator and external source
   // ****************************************************************
   // The external source clocks the input pin only while the bench asks for it.
   initial begin
      pinClk = 1'b0;
      forever begin
         @(posedge extOn);
         #3;
         while (extOn === 1'b1) begin
            #100;
            if (extOn === 1'b1) begin
               pinClk = ~pinClk;
            end
         end
         // A released pin shows the inverse of its last level.
         pinClk = ~pinClk;
      end
   end

   // The resonator only swings while the amplifier runs and stands at 0 otherwise.
   always begin
      if (ampOn === 1'b1) begin
         #(slow ? 120 : 80);
         rawClk = (ampOn === 1'b1) ? ~rawClk : 1'b0;
      end else begin
         rawClk = 1'b0;
         @(ampOn);
         #7;
      end
   end
endmodule

// ### testbench/tb_oscctl_top.sv
// Self-checking testbench of the oscillator control block.
`timescale 1ns/1ps
module tb_oscctl_top;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic        core_clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic        clockGenRequest = 1'b0, mcuStop = 1'b0, extOn = 1'b0, slow = 1'b0;
   logic        hready, hreadyout, hresp, rawResonatorClock, crystalInputPin, leak;
   logic        moduleOutputClock, rawClockGated, initDoneFlag, oscEnable;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [3:0]  v;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   oscctl_pkg::oscctl_analog_t analogCtrl;
   int          err_total = 0, tests_run = 0, rawEdges = 0, outEdges = 0, n;
   int          rawBase = 0, outBase = 0;

   always #20 core_clk = ~core_clk;
   assign hready = hreadyout;
   always @(posedge rawResonatorClock) rawEdges++;
   always @(posedge moduleOutputClock) outEdges++;

   oscctl_top oscctl_top_i (
      .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .clockGenRequest(clockGenRequest), .mcuStop(mcuStop),
      .rawResonatorClock(rawResonatorClock), .crystalInputPin(crystalInputPin),
      .moduleOutputClock(moduleOutputClock), .rawClockGated(rawClockGated),
      .initDoneFlag(initDoneFlag), .oscEnable(oscEnable), .analogCtrl(analogCtrl)
   );

   oscctl_resonator_model oscctl_resonator_model_i (
      .ampOn(analogCtrl.ampEnable & analogCtrl.pinsCoupled), .extOn(extOn), .slow(slow),
      .rawClk(rawResonatorClock), .pinClk(crystalInputPin)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // One single word transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int w;
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= oscctl_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, addr};
      hwrite <= wr;
      hsize <= oscctl_pkg::HSIZE_WORD;
      w = 0;
      do begin
         @(posedge core_clk);
         w++;
      end while (hready !== 1'b1 && w < 100);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge core_clk);
         w++;
      end while (hready !== 1'b1 && w < 200);
      rd = hrdata;
      if (w >= 100) begin
         chk(32'h0, 32'h1);
      end
   endtask

   function automatic logic expEn(input logic creq, input logic en, input logic keep,
                                  input logic stop);
      return creq | (en & (~stop | keep));
   endfunction

   function automatic oscctl_pkg::oscctl_analog_t expAna(input logic rng, input logic gain);
      return {3'b111, rng, gain, ~gain, rng & ~gain, 1'b0};
   endfunction

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   initial begin
      #2800000;
      chk(32'h0, 32'h1);
      complete_run();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      void'($urandom(41));
      cyc(8);
      nrst <= 1'b1;
      bus(1'b0, oscctl_pkg::CTRL_OFFSET, 32'h0);
      chk(rd, {24'h0, oscctl_pkg::CTRL_RESET});
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h7f);
      bus(1'b0, oscctl_pkg::CTRL_OFFSET, 32'h0);
      chk(rd, {24'h0, 8'h7f & oscctl_pkg::CTRL_WMASK});
      bus(1'b1, oscctl_pkg::STATUS_OFFSET, 32'hff);
      bus(1'b0, oscctl_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, {31'h0, oscctl_pkg::HRESP_OKAY});
      clkEn <= 1'b0;
      cyc(2);
      chk({31'h0, hreadyout}, 32'h0);
      clkEn <= 1'b1;
      for (int k = 0; k < 24; k++) begin
         v = (k < 16) ? k[3:0] : 4'($urandom);
         clockGenRequest <= v[0];
         mcuStop <= v[3];
         bus(1'b1, oscctl_pkg::CTRL_OFFSET, {24'h0, v[1], 1'b0, v[2], 5'h0});
         cyc(1);
         chk(32'(oscEnable), 32'(expEn(v[0], v[1], v[2], v[3])));
      end
      clockGenRequest <= 1'b0;
      mcuStop <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, oscctl_pkg::CTRL_OFFSET, {29'h0, m[1], m[0], 1'b0});
         bus(1'b1, oscctl_pkg::CTRL_OFFSET, {24'h0, 3'b100, 1'b1, 1'b0, m[1], m[0], 1'b0});
         cyc(2);
         chk(32'(analogCtrl), 32'(expAna(m[1], m[0])));
         bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h0);
         cyc(2);
         chk(32'(analogCtrl), 32'(oscctl_pkg::ANALOG_RESET));
         chk(32'(rawClockGated | moduleOutputClock), 32'h0);
      end
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h04);
      rawBase = rawEdges;
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h94);
      cyc(3);
      bus(1'b0, oscctl_pkg::STATUS_OFFSET, 32'h0);
      chk(32'(rd[1:0]), 32'(oscctl_pkg::OSC_STARTUP));
      leak = 1'b0;
      n = 0;
      while (initDoneFlag !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         leak = leak | moduleOutputClock;
         n++;
      end
      chk(32'(leak), 32'h0);
      chk(32'(rawEdges - rawBase >= 4096 && rawEdges - rawBase <= 4098), 32'h1);
      cyc(3);
      bus(1'b0, oscctl_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, {28'h0, 2'b11, oscctl_pkg::OSC_STABLE});
      bus(1'b0, oscctl_pkg::CTRL_OFFSET, 32'h0);
      chk(rd, 32'h95);
      outBase = outEdges;
      cyc(40);
      chk(32'(outEdges - outBase > 5), 32'h1);
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h04);
      cyc(3);
      chk(32'(initDoneFlag), 32'h0);
      outBase = outEdges;
      cyc(20);
      chk(32'(outEdges - outBase), 32'h0);
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h94);
      cyc(12000);
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h04);
      slow = 1'b1;
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h94);
      cyc(10000);
      chk(32'(initDoneFlag), 32'h0);
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h0);
      slow = 1'b0;
      extOn = 1'b1;
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h80);
      cyc(3);
      bus(1'b0, oscctl_pkg::STATUS_OFFSET, 32'h0);
      chk(32'(rd[1:0]), 32'(oscctl_pkg::OSC_EXTCLK));
      chk(32'(analogCtrl.drivePinUsed), 32'h0);
      outBase = outEdges;
      cyc(40);
      chk({30'h0, (outEdges - outBase > 5), initDoneFlag}, 32'h2);
      extOn = 1'b0;
      bus(1'b1, oscctl_pkg::CTRL_OFFSET, 32'h0);
      complete_run();
   end
endmodule
